// File: tbr_defines.vh
`ifndef TBR_DEFINES_VH
`define TBR_DEFINES_VH
// ----------------------------------------
// register byte addresses (chosen)
// ----------------------------------------
`define TBR_ADDR_PTR 12'h000
`define TBR_ADDR_HIGH 12'h004
`define TBR_ADDR_STAT 12'h008
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define TBR_PTR_RESET 8'h00
`define TBR_HIGH_RESET 8'h00
`define TBR_STAT_BUSY_BIT 0
`define TBR_STAT_LAST_BIT 1
// ----------------------------------------
// timing: instruction cycles per table read
// ----------------------------------------
`define TBR_READ_CYCLES 2
`define TBR_CYC_PER_INSTR 4
`endif

// File: tbr_rom.v
`timescale 1ns/100ps
// program memory image, registered read data
module tbr_rom #(
  parameter AW = 11,
  parameter DW = 14
) (
  input wire pclk,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // simple dual port array, separate read and write addresses, no reset on contents
  // ----------------------------------------
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: tbr_table_read.v
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "tbr_defines.vh"
// Operation
// - The 8-bit table pointer always supplies the low eight address bits of a table read.
// - A current-page read uses the running page, a last-page read uses the final page.
// - For a current-page read the pointer is an offset from the start of the running page.
// - The low byte of the fetched word goes to the data register named by the operand.
// - The remaining high bits of the word are loaded into the high-byte register at once.
// - High-byte register bits not filled by the word read back as zero.
// - The high-byte register is read-only, software writes leave it unchanged.
// - Every table read finishes in two instruction cycles, fetch and both updates included.
// - Upper address bits are the program counter's upper bits, or all ones for last page.
// - The word width of 14 or 15 bits sets how many bits reach the high-byte register.
module tbr_table_read #(
  parameter AW = 11,
  parameter DW = 14,
  parameter MADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rd_start,
  input wire rd_last_page,
  input wire [MADDR_W-1:0] rd_dest,
  input wire [AW-1:0] pc,
  input wire ptr_wr,
  input wire [7:0] ptr_wdata,
  input wire ptr_inc,
  input wire ptr_dec,
  output wire rd_busy,
  output reg rd_done,
  output reg dmem_we,
  output reg [MADDR_W-1:0] dmem_addr,
  output reg [7:0] dmem_wdata,
  output wire [7:0] table_pointer_low,
  output wire [7:0] table_high_byte,
  input wire rom_wr_en,
  input wire [AW-1:0] rom_wr_addr,
  input wire [DW-1:0] rom_wr_data
);
  // ----------------------------------------
  // constants
  // ----------------------------------------
  // cycle total kept as an integer, then cut to the counter width on purpose
  localparam integer READ_CYC_I = `TBR_READ_CYCLES * `TBR_CYC_PER_INSTR;
  localparam [5:0] TOTAL_CYC = READ_CYC_I[5:0];
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;
  localparam HB = DW - 8;

  reg [7:0] ptr_r;
  reg [7:0] high_r;
  reg [2:0] state_r;
  reg [5:0] cnt_r;
  reg last_r;
  reg [MADDR_W-1:0] dest_r;
  reg [AW-1:0] addr_r;
  wire [DW-1:0] rom_q;
  wire [AW-1:0] addr_nxt;
  wire apb_wr;
  wire hit_ptr;
  reg [31:0] rdata_nxt;
  wire [7:0] high_nxt;

  // ----------------------------------------
  // table address formation
  // ----------------------------------------
  // pointer low byte
  // upper bits from pc or ones
  assign addr_nxt = rd_last_page ? {{(AW-8){1'b1}}, ptr_r} : {pc[AW-1:8], ptr_r};

  tbr_rom #(.AW(AW), .DW(DW)) u_rom (
    .pclk(pclk),
    .rd_en(state_r == ST_FETCH),
    .rd_addr(addr_r),
    .rd_data(rom_q),
    .wr_en(rom_wr_en),
    .wr_addr(rom_wr_addr),
    .wr_data(rom_wr_data)
  );

  // ----------------------------------------
  // high byte assembly, one bit per position
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_high
      if (gi < HB) begin : g_fill
        // word bits above the low byte
        assign high_nxt[gi] = rom_q[8+gi];
      end else begin : g_zero
        assign high_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------
  // apb decode, zero wait states
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel & penable & pwrite;
  assign hit_ptr = (paddr == `TBR_ADDR_PTR);
  assign rd_busy = (state_r != ST_IDLE);
  assign table_pointer_low = ptr_r;
  assign table_high_byte = high_r;

  // read mux, unmapped addresses read zero
  always @* begin
    case (paddr)
      `TBR_ADDR_PTR: rdata_nxt = {24'h000000, ptr_r};
      `TBR_ADDR_HIGH: rdata_nxt = {24'h000000, high_r};
      `TBR_ADDR_STAT: rdata_nxt = {30'h0, last_r, rd_busy};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // read data is captured in the setup phase so it leaves a flip-flop
  // with no wait state; it shows the register as it stood one edge earlier
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // table pointer
  // ----------------------------------------
  // only APB writes and core load, increment or decrement alter pointer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= `TBR_PTR_RESET;
    end else if (apb_wr && hit_ptr) begin
      ptr_r <= pwdata[7:0];
    end else if (ptr_wr) begin
      ptr_r <= ptr_wdata;
    end else if (ptr_inc) begin
      ptr_r <= ptr_r + 8'h01;
    end else if (ptr_dec) begin
      ptr_r <= ptr_r - 8'h01;
    end
  end

  // ----------------------------------------
  // read sequencer
  // ----------------------------------------
  // a start while busy is ignored; the core never issues one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'h00;
      last_r <= 1'b0;
      dest_r <= {MADDR_W{1'b0}};
      addr_r <= {AW{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (rd_start) begin
            state_r <= ST_FETCH;
            addr_r <= addr_nxt;
            last_r <= rd_last_page;
            dest_r <= rd_dest;
            cnt_r <= 6'h01;
          end
        end
        ST_FETCH: begin
          state_r <= ST_WAIT;
          cnt_r <= cnt_r + 6'h01;
        end
        ST_WAIT: begin
          if (cnt_r == TOTAL_CYC - 6'h01) begin
            state_r <= ST_IDLE;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // result write-back on the final cycle
  // ----------------------------------------
  // high byte has no write path, so writes cannot restore it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_r <= `TBR_HIGH_RESET;
      dmem_we <= 1'b0;
      dmem_addr <= {MADDR_W{1'b0}};
      dmem_wdata <= 8'h00;
      rd_done <= 1'b0;
    end else begin
      dmem_we <= 1'b0;
      rd_done <= 1'b0;
      if (state_r == ST_WAIT && cnt_r == TOTAL_CYC - 6'h01) begin
        dmem_we <= 1'b1;
        dmem_addr <= dest_r;
        dmem_wdata <= rom_q[7:0];
        high_r <= high_nxt;
        rd_done <= 1'b1;
      end
    end
  end
endmodule

// File: tbr_props.sv
`timescale 1ns/100ps
`include "tbr_defines.vh"
// passive watch of read timing, write-back and register access
module tbr_props #(parameter DW = 14) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rd_start,
  input wire [7:0] rd_dest,
  input wire ptr_wr,
  input wire ptr_inc,
  input wire ptr_dec,
  input wire rd_busy,
  input wire rd_done,
  input wire dmem_we,
  input wire [7:0] dmem_addr,
  input wire [7:0] table_pointer_low,
  input wire [7:0] table_high_byte
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_read_time: assert property (rd_start && !rd_busy |=> rd_busy [*7]
    ##1 rd_done && dmem_we && !rd_busy) else $error("read timing");
  chk_dest_kept: assert property (rd_start && !rd_busy |-> ##9
    dmem_addr == $past(rd_dest, 9)) else $error("dest");
  chk_high_only: assert property (!rd_done |-> $stable(table_high_byte))
    else $error("high changed");
  chk_high_zero: assert property (table_high_byte[7:DW-8] == '0)
    else $error("high bits");
  chk_ptr_keep: assert property (!(ptr_wr || ptr_inc || ptr_dec || psel && pwrite)
    |=> $stable(table_pointer_low)) else $error("pointer");
  chk_ptr_read: assert property (psel && penable && !pwrite && paddr == `TBR_ADDR_PTR
    |-> prdata == {24'h0, $past(table_pointer_low)}) else $error("ptr read");
  chk_high_read: assert property (psel && penable && !pwrite && paddr == `TBR_ADDR_HIGH
    |-> prdata == {24'h0, $past(table_high_byte)}) else $error("high read");
  chk_no_wait: assert property (psel |-> pready && !pslverr) else $error("apb");
endmodule

bind tbr_table_read tbr_props #(.DW(DW)) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rd_start(rd_start),
  .rd_dest(rd_dest),
  .ptr_wr(ptr_wr),
  .ptr_inc(ptr_inc),
  .ptr_dec(ptr_dec),
  .rd_busy(rd_busy),
  .rd_done(rd_done),
  .dmem_we(dmem_we),
  .dmem_addr(dmem_addr),
  .table_pointer_low(table_pointer_low),
  .table_high_byte(table_high_byte)
);

// File: tbr_core.sv
`timescale 1ns/100ps
// core side: executes table-read instructions
module tbr_core (
  input wire pclk,
  output logic rd_start,
  output logic rd_last_page,
  output logic [7:0] rd_dest,
  output logic [10:0] pc
);
  initial {rd_start, rd_last_page, rd_dest, pc} = '0;
  task issue(input logic lp, input logic [7:0] d, input logic [10:0] p);
    rd_start <= 1'h1;
    rd_last_page <= lp;
    rd_dest <= d;
    pc <= p;
    @(posedge pclk);
    rd_start <= 1'h0;
    // operand and page move on, so a late sample shows up wrong
    rd_dest <= ~d;
    pc <= ~p;
  endtask
endmodule

// File: tb_tbr_table_read.sv
`timescale 1ns/100ps
`include "tbr_defines.vh"
module tb_tbr_table_read;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rom_wr_en = 0, ptr_dec = 0;
  logic ptr_wr = 0, ptr_inc = 0;
  logic [7:0] ptr_wdata = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [10:0] rom_wr_addr = 0;
  logic [13:0] rom_wr_data = 0;
  wire [31:0] prdata;
  wire [10:0] pc;
  wire [7:0] rd_dest, dmem_addr, dmem_wdata, table_pointer_low, table_high_byte;
  wire pready, pslverr, rd_start, rd_last_page, rd_busy, rd_done, dmem_we;
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #50 pclk = ~pclk;
  tbr_core u_tbr_core (.*);
  tbr_table_read #(.AW(11), .DW(14)) u_tbr_table_read (.*);
  // hang guard, far above the roughly 63 cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 2000) begin
      num_errors++;
      final_report;
    end
  end
  task final_report;
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rom(input logic [10:0] a, input logic [13:0] d);
    rom_wr_en <= 1'h1;
    rom_wr_addr <= a;
    rom_wr_data <= d;
    @(posedge pclk);
    rom_wr_en <= 1'h0;
    @(posedge pclk);
  endtask
  // one read; negedge sampling keeps clear of the update edge
  task tread(input logic lp, input logic [10:0] p, input logic [13:0] w, input logic [7:0] pe);
    int n;
    u_tbr_core.issue(lp, 8'h5A, p);
    @(negedge pclk);
    chk(rd_busy, 1'h1);
    n = 1;
    while (rd_done !== 1'h1 && n < 12) begin
      @(negedge pclk);
      n++;
    end
    chk(n, `TBR_READ_CYCLES * `TBR_CYC_PER_INSTR);
    chk(rd_done, 1'h1);
    chk(rd_busy, 1'h0);
    chk(dmem_we, 1'h1);
    chk(dmem_addr, 8'h5A);
    chk(dmem_wdata, w[7:0]);
    chk(table_high_byte, {2'h0, w[13:8]});
    chk(table_pointer_low, pe);
    @(posedge pclk);
  endtask
  task t_last;
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h000, 32'h06);
    tread(1'h1, 11'h345, 14'h3F1A, 8'h06);
    ptr_dec <= 1'h1;
    @(posedge pclk);
    ptr_dec <= 1'h0;
    tread(1'h1, 11'h0FF, 14'h000F, 8'h05);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h2);
  endtask
  // pointer reached through software write, core load and increment
  task t_cur;
    apb(1'h1, 12'h000, 32'h20);
    ptr_wr <= 1'h1;
    ptr_wdata <= 8'h05;
    @(posedge pclk);
    ptr_wr <= 1'h0;
    ptr_inc <= 1'h1;
    @(posedge pclk);
    ptr_inc <= 1'h0;
    tread(1'h0, 11'h345, 14'h2A5C, 8'h06);
  endtask
  // high byte ignores writes; unmapped reads as zero
  task t_ro;
    apb(1'h1, 12'h004, 32'hFF);
    apb(1'h0, 12'h004, 32'h0);
    chk(rd, 32'h2A);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h06);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rom(11'h706, 14'h3F1A);
    rom(11'h705, 14'h000F);
    rom(11'h306, 14'h2A5C);
    t_last;
    t_cur;
    t_ro;
    final_report;
  end
endmodule
